/* File: psw_power_state_wakeup_control.sv */
/*
 Power-state sequencer: powerdown, regulator ramp, power-on reset, oscillator
 start, standby, active and sleep, with wake by address 0 read and pin freeze.
 Assumes the host interface flags address 0 reads and the low power commands
 as one-cycle pulses synchronous to mclk_i.
*/
`timescale 1ns/10ps
module psw_power_state_wakeup_control (
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	// Power-down pin
	input  wire logic             power_down_n_pin_i,
	// Host requests
	input  wire logic             rd_addr0_i,
	input  wire logic             cmd_standby_i,
	input  wire logic             cmd_sleep_i,
	input  wire logic             cmd_powerdown_i,
	// Engine pins
	input  wire psw_pkg::psw_pins_s eng_pins_i,
	output psw_pkg::psw_pins_s    pins_o,
	// Power controls
	output logic                  reg_en_o,
	output logic                  core_rst_o,
	output logic                  osc_en_o,
	output logic                  eng_clk_en_o,
	output logic                  host_ready_o,
	output logic                  asleep_o
);

	localparam logic [19:0] RAMP_LAST = 20'(psw_pkg::REG_RAMP_CYC - 1);
	localparam logic [19:0] POR_LAST  = 20'(psw_pkg::POR_CYC - 1);
	localparam logic [19:0] OSC_LAST  = 20'(psw_pkg::OSC_LOCK_CYC - 1);
	localparam logic [19:0] SEQ_LAST  = 20'(psw_pkg::REG_RAMP_CYC + psw_pkg::POR_CYC + psw_pkg::OSC_LOCK_CYC - 1);

	psw_pkg::psw_state_e state_q;
	psw_pkg::psw_state_e state_d;
	logic [psw_pkg::CNT_W-1:0] cnt_q;
	logic [psw_pkg::CNT_W-1:0] wake_cyc_q;
	logic                      pin_q;
	logic                      sleep_q;
	logic                      rise;
	logic                      live;
	logic                      clear;

	assign rise = power_down_n_pin_i && !pin_q;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= power_down_n_pin_i;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			psw_pkg::PSW_POWERDOWN: begin
				if (rise) begin
					state_d = psw_pkg::PSW_RAMP;
				end
			end
			psw_pkg::PSW_RAMP: begin
				if (cnt_q == RAMP_LAST) begin
					state_d = psw_pkg::PSW_POR;
				end
			end
			psw_pkg::PSW_POR: begin
				if (cnt_q == POR_LAST) begin
					state_d = psw_pkg::PSW_OSC_UP;
				end
			end
			psw_pkg::PSW_OSC_UP: begin
				if (cnt_q == OSC_LAST) begin
					state_d = psw_pkg::PSW_STANDBY;
				end
			end
			psw_pkg::PSW_STANDBY: begin
				if (rd_addr0_i) begin
					state_d = psw_pkg::PSW_ACTIVE;
				end
			end
			psw_pkg::PSW_ACTIVE: begin
				if (cmd_standby_i || cmd_sleep_i) begin
					state_d = psw_pkg::PSW_STANDBY;
				end
			end
			default: begin
				state_d = psw_pkg::PSW_POWERDOWN;
			end
		endcase
		if (!power_down_n_pin_i || cmd_powerdown_i) begin
			state_d = psw_pkg::PSW_POWERDOWN;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_q <= psw_pkg::PSW_POWERDOWN;
		end else begin
			state_q <= state_d;
		end
	end

	// Sleep is standby with the oscillator off; wake restarts the oscillator
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || state_d == psw_pkg::PSW_POWERDOWN) begin
			sleep_q <= 1'b0;
		end else if (state_q == psw_pkg::PSW_ACTIVE && cmd_sleep_i && !cmd_standby_i) begin
			sleep_q <= 1'b1;
		end else if (state_q == psw_pkg::PSW_STANDBY && rd_addr0_i) begin
			sleep_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || state_d != state_q) begin
			cnt_q <= '0;
		end else if (cnt_q != '1) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// Oscillator ramp after sleep is the host's 20ms wait, not ours
	assign live  = (state_q == psw_pkg::PSW_ACTIVE) && (state_d == psw_pkg::PSW_ACTIVE);
	assign clear = (state_q == psw_pkg::PSW_POR);

	psw_freeze u_freeze (
		.mclk_i     (mclk_i),
		.rst_n_i    (rst_n_i),
		.live_i     (live),
		.clear_i    (clear),
		.eng_pins_i (eng_pins_i),
		.pins_o     (pins_o)
	);

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			reg_en_o     <= 1'b0;
			core_rst_o   <= 1'b1;
			osc_en_o     <= 1'b0;
			eng_clk_en_o <= 1'b0;
			host_ready_o <= 1'b0;
			asleep_o     <= 1'b0;
		end else begin
			reg_en_o     <= (state_d != psw_pkg::PSW_POWERDOWN);
			core_rst_o   <= (state_d == psw_pkg::PSW_POWERDOWN) || (state_d == psw_pkg::PSW_RAMP)
			                || (state_d == psw_pkg::PSW_POR);
			osc_en_o     <= ((state_d == psw_pkg::PSW_OSC_UP) || (state_d == psw_pkg::PSW_STANDBY)
			                || (state_d == psw_pkg::PSW_ACTIVE)) && !(sleep_q && state_d == psw_pkg::PSW_STANDBY
			                && !(rd_addr0_i && state_q == psw_pkg::PSW_STANDBY));
			eng_clk_en_o <= (state_d == psw_pkg::PSW_ACTIVE);
			host_ready_o <= (state_d == psw_pkg::PSW_STANDBY) || (state_d == psw_pkg::PSW_ACTIVE);
			asleep_o     <= (state_d == psw_pkg::PSW_STANDBY) && sleep_q
			                && !(rd_addr0_i && state_q == psw_pkg::PSW_STANDBY);
		end
	end

	sequence s_rise;
		$rose(power_down_n_pin_i) && state_q == psw_pkg::PSW_POWERDOWN;
	endsequence

	property p_rise_ramp;
		@(posedge mclk_i) disable iff (!rst_n_i)
		s_rise ##0 !cmd_powerdown_i |=> state_q == psw_pkg::PSW_RAMP;
	endproperty
	a_rise_ramp: assert property (p_rise_ramp) else $error("Pin rise did not start ramp");

	// Wake sequence length counter; too long for a delay range
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || state_q == psw_pkg::PSW_POWERDOWN || state_q == psw_pkg::PSW_STANDBY
		    || state_q == psw_pkg::PSW_ACTIVE) begin
			wake_cyc_q <= '0;
		end else if (wake_cyc_q != '1) begin
			wake_cyc_q <= wake_cyc_q + 1'b1;
		end
	end

	// Whole sequence sits far inside the 20ms ceiling
	property p_wake_bound;
		@(posedge mclk_i) disable iff (!rst_n_i)
		wake_cyc_q == SEQ_LAST |=> state_q == psw_pkg::PSW_STANDBY || state_q == psw_pkg::PSW_POWERDOWN;
	endproperty
	a_wake_bound: assert property (p_wake_bound) else $error("Standby not reached in time");

	property p_pd_force;
		@(posedge mclk_i) disable iff (!rst_n_i)
		!power_down_n_pin_i |=> state_q == psw_pkg::PSW_POWERDOWN && !reg_en_o;
	endproperty
	a_pd_force: assert property (p_pd_force) else $error("Pin low did not force powerdown");

	property p_leave_pd;
		@(posedge mclk_i) disable iff (!rst_n_i)
		state_q == psw_pkg::PSW_POWERDOWN ##1 state_q != psw_pkg::PSW_POWERDOWN |-> $rose(pin_q);
	endproperty
	a_leave_pd: assert property (p_leave_pd) else $error("Powerdown left without pin edge");

	property p_por_first;
		@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(state_q == psw_pkg::PSW_OSC_UP) |-> $past(core_rst_o);
	endproperty
	a_por_first: assert property (p_por_first) else $error("Oscillator start without reset");

	property p_wake;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(state_q == psw_pkg::PSW_STANDBY && rd_addr0_i && power_down_n_pin_i && !cmd_powerdown_i)
		|=> state_q == psw_pkg::PSW_ACTIVE ##1 eng_clk_en_o;
	endproperty
	a_wake: assert property (p_wake) else $error("Address 0 read did not wake");

	property p_engines;
		@(posedge mclk_i) disable iff (!rst_n_i)
		eng_clk_en_o |-> $past(state_q) == psw_pkg::PSW_ACTIVE || state_q == psw_pkg::PSW_ACTIVE;
	endproperty
	a_engines: assert property (p_engines) else $error("Engines clocked outside active");

	property p_standby_osc;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(state_q == psw_pkg::PSW_STANDBY && !sleep_q)[*2] |-> osc_en_o && !eng_clk_en_o;
	endproperty
	a_standby_osc: assert property (p_standby_osc) else $error("Standby clocks wrong");

	property p_ready;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(state_q == psw_pkg::PSW_STANDBY)[*2] |-> host_ready_o;
	endproperty
	a_ready: assert property (p_ready) else $error("Standby not ready for host");

endmodule : psw_power_state_wakeup_control

/* File: psw_pkg.sv */
/*
 Package for the power-state sequencer: states, timing counts, pin carrier struct.
 Assumes a single 50 MHz clock and a host decoder that flags reads of address 0.
*/
// Behaviour
// - Powerdown left only on power-down pin rising edge
// - Power-on reset clears core after supply stable
// - Standby within 20ms of pin rising edge
// - Address 0 read in sleep goes active
// - Address 0 read in standby goes active
// - Standby wake accepts access immediately
// - Pins frozen on active to standby or sleep
// - After power-on reset, settle in standby
// - Power-down pin low forces powerdown anywhere
// - Standby keeps oscillator, gates engine clock, retains
// - Engines run only in active state
package psw_pkg;

	localparam int unsigned CLK_HZ         = 50_000_000;
	localparam int unsigned WAKE_MAX_MS    = 20;
	localparam int unsigned WAKE_MAX_CYC   = (CLK_HZ / 1000) * WAKE_MAX_MS;
	localparam int unsigned REG_RAMP_CYC   = 1024;
	localparam int unsigned POR_CYC        = 16;
	localparam int unsigned OSC_LOCK_CYC   = 4096;
	localparam int unsigned CNT_W          = 20;
	localparam int unsigned PIN_W          = 16;
	localparam logic [PIN_W-1:0] PIN_RST_VAL = 16'h0000;

	typedef enum logic [5:0] {
		PSW_POWERDOWN = 6'b000001,
		PSW_RAMP      = 6'b000010,
		PSW_POR       = 6'b000100,
		PSW_OSC_UP    = 6'b001000,
		PSW_STANDBY   = 6'b010000,
		PSW_ACTIVE    = 6'b100000
	} psw_state_e;

	typedef struct packed {
		logic [PIN_W-1:0] level;
		logic [PIN_W-1:0] oe;
	} psw_pins_s;

endpackage : psw_pkg

/* File: psw_freeze.sv */
/*
 Pin freeze stage: passes engine pin values while live, clears them on clear, holds them otherwise.
 Assumes live drops in the same cycle the state leaves active.
*/
`timescale 1ns/10ps
module psw_freeze (
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	// Control
	input  wire logic             live_i,
	input  wire logic             clear_i,
	// Pins
	input  wire psw_pkg::psw_pins_s eng_pins_i,
	output psw_pkg::psw_pins_s    pins_o
);

	psw_pkg::psw_pins_s pins_q;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || clear_i) begin
			pins_q <= '{level: psw_pkg::PIN_RST_VAL, oe: psw_pkg::PIN_RST_VAL};
		end else if (live_i) begin
			pins_q <= eng_pins_i;
		end
	end

	assign pins_o = pins_q;

	property p_hold;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(!live_i && !clear_i) |=> (pins_q == $past(pins_q));
	endproperty
	a_hold: assert property (p_hold) else $error("Pins changed while frozen");

endmodule : psw_freeze

/* File: psw_host_model.sv */
/*
 Host model: drives the power-down pin, address 0 reads, power commands, engine pins.
 Assumes the device samples all of them on mclk_i rising edges.
*/
`timescale 1ns/10ps
module psw_host_model #(
	parameter int unsigned SLEEP_WAIT_CYC = 64
) (
	input  wire logic          mclk_i,
	output logic               pin_o,
	output logic [3:0]         cmd_o,
	output psw_pkg::psw_pins_s eng_pins_o
);
	logic asleep = 1'b0;

	initial begin
		pin_o = 1'b0;
		cmd_o = 4'h0;
		eng_pins_o = '0;
	end

	// Clock enable sequence lives outside this block
	task automatic pd(input logic v);
		@(posedge mclk_i);
		pin_o <= v;
	endtask : pd

	// Bit 0 read, 1 standby, 2 sleep, 3 powerdown
	task automatic req(input int k);
		@(posedge mclk_i);
		cmd_o <= 4'(1 << k);
		@(posedge mclk_i);
		cmd_o <= 4'h0;
		if (k == 0 && asleep) begin
			// Shortened wait, oscillator restart
			repeat (SLEEP_WAIT_CYC) @(posedge mclk_i);
		end
		asleep = (k == 2) ? 1'b1 : ((k == 0) ? 1'b0 : asleep);
	endtask : req

	task automatic pins(input psw_pkg::psw_pins_s v);
		@(posedge mclk_i);
		eng_pins_o <= v;
	endtask : pins
endmodule : psw_host_model

/* File: tb.sv */
/*
 Testbench for the power-state sequencer: reset and wake, then rows of wake and sleep
 steps, then pin freeze and powerdown cases. Assumes the host model drives all inputs but clock and reset.
*/
`timescale 1ns/10ps
module tb;
	typedef struct {
		int         op;
		logic [2:0] exp;
	} psw_row_s;

	logic               mclk_i;
	logic               rst_n_i;
	logic               pin;
	logic [3:0]         cmd;
	logic               rd_addr0, cmd_standby, cmd_sleep, cmd_powerdown;
	psw_pkg::psw_pins_s eng_pins;
	psw_pkg::psw_pins_s pins_o;
	logic               reg_en, core_rst, osc_en, eng_clk_en, host_ready, asleep;
	int                 failures = 0;
	int                 check_count = 0;
	int                 n;
	// Expect {engine clock, asleep, oscillator}
	psw_row_s rows [6] = '{'{0, 3'b101}, '{2, 3'b010}, '{0, 3'b101},
		'{1, 3'b001}, '{2, 3'b001}, '{0, 3'b101}};

	assign {cmd_powerdown, cmd_sleep, cmd_standby, rd_addr0} = cmd;

	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end

	psw_host_model host (.mclk_i(mclk_i), .pin_o(pin), .cmd_o(cmd), .eng_pins_o(eng_pins));

	psw_power_state_wakeup_control dut (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .power_down_n_pin_i(pin),
		.rd_addr0_i(rd_addr0), .cmd_standby_i(cmd_standby), .cmd_sleep_i(cmd_sleep),
		.cmd_powerdown_i(cmd_powerdown), .eng_pins_i(eng_pins), .pins_o(pins_o),
		.reg_en_o(reg_en), .core_rst_o(core_rst), .osc_en_o(osc_en),
		.eng_clk_en_o(eng_clk_en), .host_ready_o(host_ready), .asleep_o(asleep)
	);

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	// Bound well under the 20ms ceiling
	task automatic wake();
		host.pd(1'b0);
		host.pd(1'b1);
		n = 0;
		while (host_ready !== 1'b1 && n < 6000) begin
			@(negedge mclk_i);
			n++;
		end
		check("wake_time", 32'(n <= 5140), 32'h1);
		check("wake_out", {reg_en, core_rst, osc_en, eng_clk_en}, 4'b1010);
		check("wake_pins", pins_o, 32'h0);
	endtask : wake

	initial begin
		rst_n_i <= 1'b0;
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(negedge mclk_i);
		check("rst_out", {reg_en, core_rst, osc_en, eng_clk_en, host_ready, asleep}, 6'h10);
		check("rst_pins", pins_o, 32'h0);
		wake();
		$display("test reset_wake done");
		foreach (rows[i]) begin
			host.req(rows[i].op);
			repeat (3) @(negedge mclk_i);
			check("row", {eng_clk_en, asleep, osc_en}, rows[i].exp);
		end
		$display("test rows done");
		host.pins('{16'h1234, 16'hff00});
		repeat (3) @(negedge mclk_i);
		check("live_pins", pins_o, 32'h1234ff00);
		host.req(1);
		host.pins('{16'h5a5a, 16'h00ff});
		repeat (3) @(negedge mclk_i);
		check("frozen_pins", pins_o, 32'h1234ff00);
		$display("test freeze done");
		host.req(0);
		host.req(3);
		repeat (50) @(negedge mclk_i);
		check("pd_cmd", {reg_en, host_ready, eng_clk_en}, 3'b000);
		wake();
		host.pd(1'b0);
		repeat (3) @(negedge mclk_i);
		check("pd_pin", {reg_en, host_ready}, 2'b00);
		$display("test powerdown done");
		summarize();
	end

	initial begin
		#(40000 * 20);
		failures++;
		summarize();
	end
endmodule : tb
